// >>> rtl/iep_regs.vh
// Purpose: Register map, field positions and reset values of the interrupt enable block.
// Assumes: APB with 32-bit data; printed offsets are register indexes, byte address is 4x.
// Notes: Included by the top module only; its two helpers do not use it.
// Notes on behaviour
// R1 - Two enable bits give disabled or levels 1-3.
// R2 - High register bits: timer, uart rx/tx, port C.
// R3 - Low register uses the same bit mapping.
// R4 - Software writes zero to reserved bits.
// R5 - Polarity 0 falling edge, 1 rising edge.
// R6 - Select bit 7 picks pin 7 or voltage detector.
// R7 - Select bit 6 picks pin 6 or comparator 0.
// R8 - Select bit 5 picks pin 5 or comparator 1.
// R9 - Select bits 4-1 pick port A or D pin.
// R10 - Control bit 7 is master interrupt enable.
// R11 - Enable, return instruction or write 1 sets it.
// R12 - Disable, acknowledge, reset or write 0 clears it.
// R13 - Control bits 6-0 read zero, read-only.
// R14 - Requests pass only when enabled; highest level first.
// R15 - Config bits reset zero, software read/write.
`ifndef IEP_REGS_VH
`define IEP_REGS_VH
`define IEP_IDX_G2_HIGH     12'hFC7
`define IEP_IDX_G2_LOW      12'hFC8
`define IEP_IDX_EDGE        12'hFCD
`define IEP_IDX_SHARED      12'hFCE
`define IEP_IDX_CTRL        12'hFCF
`define IEP_IDX_EVT_STATUS  12'hFD0
`define IEP_IDX_EVT_MASK    12'hFD1
`define IEP_RESET_BYTE      8'h00
`define IEP_G2_USED_MASK    8'h7F
`define IEP_SHARED_USED_MASK 8'hFE
`define IEP_CTRL_ENABLE_BIT 7
`define IEP_EVT_BITS        3
`define IEP_EVT_SET         0
`define IEP_EVT_CLEAR       1
`define IEP_EVT_GRANT       2
`endif

// >>> rtl/iep_edge_detect.v
// Purpose: Per-pin edge detector with selectable polarity.
// Assumes: Pins are synchronous to clk.
// Notes: One-cycle pulse per selected edge.
`timescale 1ns/10ps
`default_nettype none
module iep_edge_detect #(
    parameter WIDTH = 8
) (
    input  wire             clk,        // System clock.
    input  wire             rst,        // Asynchronous reset, active high.
    input  wire [WIDTH-1:0] pin,        // Selected pin levels.
    input  wire [WIDTH-1:0] rising,     // 1 rising edge, 0 falling edge.
    output wire [WIDTH-1:0] edge_pulse  // Edge seen this cycle.
);
    reg [WIDTH-1:0] prev_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_q <= {WIDTH{1'b0}};
        end else begin
            prev_q <= pin;
        end
    end

    assign edge_pulse = (rising & pin & ~prev_q) | (~rising & ~pin & prev_q); // [R5]
endmodule // iep_edge_detect
`default_nettype wire

// >>> rtl/iep_prio_select.v
// Purpose: Picks the highest-priority enabled pending request of group 2.
// Assumes: Ties at one level go to the higher bit index.
// Notes: Combinational.
`timescale 1ns/10ps
`default_nettype none
module iep_prio_select #(
    parameter N = 7
) (
    input  wire [N-1:0] pending,   // Latched requests.
    input  wire [N-1:0] en_high,   // High enable bits.
    input  wire [N-1:0] en_low,    // Low enable bits.
    input  wire         master_en, // Global enable.
    output reg          valid,     // A request is presented.
    output reg  [2:0]   index,     // Chosen source.
    output reg  [1:0]   level      // Its priority level.
);
    integer i;
    reg [1:0] code;

    always @* begin
        valid = 1'b0;
        index = 3'h0;
        level = 2'h0;
        code  = 2'h0;
        for (i = 0; i < N; i = i + 1) begin
            code = {en_high[i], en_low[i]}; // [R1] [R3]
            if (master_en && pending[i] && code != 2'h0 && code >= level) begin // [R14]
                valid = 1'b1;
                index = i[2:0];
                level = code;
            end
        end
    end
endmodule // iep_prio_select
`default_nettype wire

// >>> rtl/iep_top.v
// Purpose: Group-2 priority enables, edge select, shared source select, master enable.
// Assumes: APB slave, zero wait states; core events are one-cycle pulses.
// Notes: Event status bits are cleared by reading the status register.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "iep_regs.vh"
module iep_top #(
    parameter N_G2 = 7
) (
    input  wire             clk,          // System clock, 10 MHz.
    input  wire             rst,          // Asynchronous reset, active high.
    input  wire             psel,         // APB select.
    input  wire             penable,      // APB access phase.
    input  wire             pwrite,       // APB write.
    input  wire [15:0]      paddr,        // APB byte address.
    input  wire [31:0]      pwdata,       // APB write data.
    output wire             pready,       // APB ready.
    output reg  [31:0]      prdata,       // APB read data.
    output wire             pslverr,      // APB error on unmapped address.
    input  wire             ei_pulse,     // Enable-interrupts instruction executed.
    input  wire             interrupt_return_instruction_pulse,   // Interrupt-return instruction executed.
    input  wire             di_pulse,     // Disable-interrupts instruction executed.
    input  wire             ack_pulse,    // Core acknowledges a request.
    input  wire [N_G2-1:0]  g2_pending,   // Latched group-2 requests.
    input  wire [7:0]       port_a,       // Port A pins.
    input  wire [4:1]       port_d,       // Port D pins 1 to 4.
    input  wire             low_voltage,  // Low-voltage detector output.
    input  wire             comp0,        // Comparator 0 output.
    input  wire             comp1,        // Comparator 1 output.
    output reg  [7:0]       pin_request,  // Edge request per line, one cycle.
    output reg              req_valid,    // Group-2 request presented to core.
    output reg  [2:0]       req_index,    // Chosen group-2 source.
    output reg  [1:0]       req_level,    // Its priority level.
    output wire             global_interrupt_enable, // Master enable state.
    output wire             irq           // Event interrupt, level.
);
    reg  [7:0] prio_high_q;
    reg  [7:0] prio_low_q;
    reg  [7:0] edge_q;
    reg  [7:0] shared_q;
    reg        master_q;
    reg  [`IEP_EVT_BITS-1:0] evt_status_q;
    reg  [`IEP_EVT_BITS-1:0] evt_mask_q;
    reg  [`IEP_EVT_BITS-1:0] evt_d;
    reg  [7:0] line;
    reg  [31:0] rdata_d;
    reg        mapped;

    wire [11:0] idx = paddr[13:2];
    wire        acc = psel && penable;
    wire        wr  = acc && pwrite;
    wire        rd  = acc && !pwrite;
    wire [7:0]  wb  = pwdata[7:0];
    wire [7:0]  edge_pulse;
    wire        sel_valid;
    wire [2:0]  sel_index;
    wire [1:0]  sel_level;

    function hit;
        input [11:0] a;
        input [11:0] want;
        begin
            hit = (a == want);
        end
    endfunction

    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign global_interrupt_enable = master_q; // [R10]
    assign irq = |(evt_status_q & evt_mask_q);

    // Alternate sources are multiplexed onto the request lines.
    always @* begin
        line    = port_a;
        line[7] = shared_q[7] ? low_voltage : port_a[7]; // [R6]
        line[6] = shared_q[6] ? comp0 : port_a[6];       // [R7]
        line[5] = shared_q[5] ? comp1 : port_a[5];       // [R8]
        line[4] = shared_q[4] ? port_d[4] : port_a[4];   // [R9]
        line[3] = shared_q[3] ? port_d[3] : port_a[3];   // [R9]
        line[2] = shared_q[2] ? port_d[2] : port_a[2];   // [R9]
        line[1] = shared_q[1] ? port_d[1] : port_a[1];   // [R9]
    end

    iep_edge_detect #(
        .WIDTH (8)
    ) u_edge (
        .clk        (clk),
        .rst        (rst),
        .pin        (line),
        .rising     (edge_q),
        .edge_pulse (edge_pulse)
    );

    iep_prio_select #(
        .N (N_G2)
    ) u_prio (
        .pending   (g2_pending),
        .en_high   (prio_high_q[N_G2-1:0]), // [R2]
        .en_low    (prio_low_q[N_G2-1:0]),  // [R3]
        .master_en (master_q),
        .valid     (sel_valid),
        .index     (sel_index),
        .level     (sel_level)
    );

    // Read decode.
    always @* begin
        mapped  = 1'b1;
        rdata_d = 32'h0000_0000;
        if (hit(idx, `IEP_IDX_G2_HIGH)) begin
            rdata_d[7:0] = prio_high_q;
        end else if (hit(idx, `IEP_IDX_G2_LOW)) begin
            rdata_d[7:0] = prio_low_q;
        end else if (hit(idx, `IEP_IDX_EDGE)) begin
            rdata_d[7:0] = edge_q;
        end else if (hit(idx, `IEP_IDX_SHARED)) begin
            rdata_d[7:0] = shared_q;
        end else if (hit(idx, `IEP_IDX_CTRL)) begin
            rdata_d[`IEP_CTRL_ENABLE_BIT] = master_q; // [R13]
        end else if (hit(idx, `IEP_IDX_EVT_STATUS)) begin
            rdata_d[`IEP_EVT_BITS-1:0] = evt_status_q;
        end else if (hit(idx, `IEP_IDX_EVT_MASK)) begin
            rdata_d[`IEP_EVT_BITS-1:0] = evt_mask_q;
        end else begin
            mapped = 1'b0;
        end
    end

    // Events: set wins over the clear-on-read.
    always @* begin
        evt_d = evt_status_q;
        // Only the bits captured for this read in its setup cycle are cleared.
        // An event that lands on the setup edge is kept for the next read.
        if (rd && hit(idx, `IEP_IDX_EVT_STATUS)) begin
            evt_d = evt_status_q & ~prdata[`IEP_EVT_BITS-1:0];
        end
        if (ei_pulse || interrupt_return_instruction_pulse) begin
            evt_d[`IEP_EVT_SET] = 1'b1;
        end
        if (di_pulse) begin
            evt_d[`IEP_EVT_CLEAR] = 1'b1;
        end
        if (ack_pulse) begin
            evt_d[`IEP_EVT_GRANT] = 1'b1;
        end
    end

    // Configuration registers; reserved bits are held at zero.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            prio_high_q  <= `IEP_RESET_BYTE; // [R15]
            prio_low_q   <= `IEP_RESET_BYTE;
            edge_q       <= `IEP_RESET_BYTE;
            shared_q     <= `IEP_RESET_BYTE;
            evt_mask_q   <= {`IEP_EVT_BITS{1'b0}};
        end else if (wr) begin
            if (hit(idx, `IEP_IDX_G2_HIGH)) begin
                prio_high_q <= wb & `IEP_G2_USED_MASK; // [R2] [R4]
            end
            if (hit(idx, `IEP_IDX_G2_LOW)) begin
                prio_low_q <= wb & `IEP_G2_USED_MASK; // [R3] [R4]
            end
            if (hit(idx, `IEP_IDX_EDGE)) begin
                edge_q <= wb; // [R5] [R15]
            end
            if (hit(idx, `IEP_IDX_SHARED)) begin
                shared_q <= wb & `IEP_SHARED_USED_MASK; // [R4]
            end
            if (hit(idx, `IEP_IDX_EVT_MASK)) begin
                evt_mask_q <= wb[`IEP_EVT_BITS-1:0];
            end
        end
    end

    // Master enable: clearing events take precedence over setting ones.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            master_q <= 1'b0; // [R12]
        end else if (di_pulse || ack_pulse) begin
            master_q <= 1'b0; // [R12]
        end else if (ei_pulse || interrupt_return_instruction_pulse) begin
            master_q <= 1'b1; // [R11]
        end else if (wr && hit(idx, `IEP_IDX_CTRL)) begin
            master_q <= wb[`IEP_CTRL_ENABLE_BIT]; // [R11] [R12]
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_status_q <= {`IEP_EVT_BITS{1'b0}};
            prdata       <= 32'h0000_0000;
            pin_request  <= 8'h00;
            req_valid    <= 1'b0;
            req_index    <= 3'h0;
            req_level    <= 2'h0;
        end else begin
            evt_status_q <= evt_d;
            pin_request  <= edge_pulse; // [R5]
            req_valid    <= sel_valid;  // [R14]
            req_index    <= sel_index;
            req_level    <= sel_level;
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end
endmodule // iep_top
`default_nettype wire

// >>> sim/iep_top_monitor.sv
// Purpose: Port-side checker for iep_top.
// Assumes: Zero-wait APB slave; core events are one-cycle pulses.
// Notes: Attached by the bind after the module.
`timescale 1ns/10ps
`default_nettype none
module iep_top_monitor (
    input wire logic        clk,                     // Clock.
    input wire logic        rst,                     // Reset.
    input wire logic        psel,                    // Select.
    input wire logic        penable,                 // Access phase.
    input wire logic        pwrite,                  // Write.
    input wire logic [15:0] paddr,                   // Address.
    input wire logic [31:0] pwdata,                  // Write data.
    input wire logic [31:0] prdata,                  // Read data.
    input wire logic        pslverr,                 // Error.
    input wire logic        ei_pulse,                // Enable event.
    input wire logic        interrupt_return_instruction_pulse,              // Return event.
    input wire logic        di_pulse,                // Disable event.
    input wire logic        ack_pulse,               // Acknowledge.
    input wire logic [6:0]  g2_pending,              // Pending requests.
    input wire logic        req_valid,               // Request valid.
    input wire logic [2:0]  req_index,               // Request source.
    input wire logic [1:0]  req_level,               // Request level.
    input wire logic        global_interrupt_enable  // Master enable.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire acc    = psel && penable;
    wire ctl_wr = acc && pwrite && paddr[13:2] == 12'hFCF;
    sequence s_set; (ei_pulse || interrupt_return_instruction_pulse) && !di_pulse && !ack_pulse; endsequence
    sequence s_clr; di_pulse || ack_pulse; endsequence
    property p_clr; s_clr |=> !global_interrupt_enable; endproperty
    a_clr: assert property (p_clr) else $error("enable not cleared");
    property p_set; s_set ##0 !psel |=> global_interrupt_enable; endproperty
    a_set: assert property (p_set) else $error("enable not set");
    property p_wr1; ctl_wr && pwdata[7] && !di_pulse && !ack_pulse |=> global_interrupt_enable;
    endproperty
    a_wr1: assert property (p_wr1) else $error("write one lost");
    property p_wr0; ctl_wr && !pwdata[7] && !ei_pulse && !interrupt_return_instruction_pulse |=> !global_interrupt_enable;
    endproperty
    a_wr0: assert property (p_wr0) else $error("write zero lost");
    property p_gate; req_valid |-> $past(global_interrupt_enable) && req_level != 2'h0; endproperty
    a_gate: assert property (p_gate) else $error("request not gated");
    property p_pend; req_valid |-> (($past(g2_pending) >> req_index) & 7'h01) != 7'h00; endproperty
    a_pend: assert property (p_pend) else $error("source not pending");
    property p_ctl_rd; acc && !pwrite && paddr[13:2] == 12'hFCF |-> prdata[6:0] == 7'h00;
    endproperty
    a_ctl_rd: assert property (p_ctl_rd) else $error("control low bits set");
    property p_err; acc && paddr[13:2] == 12'h000 |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
endmodule // iep_top_monitor
bind iep_top iep_top_monitor u_mon (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .ei_pulse(ei_pulse), .interrupt_return_instruction_pulse(interrupt_return_instruction_pulse), .di_pulse(di_pulse), .ack_pulse(ack_pulse),
    .g2_pending(g2_pending), .req_valid(req_valid), .req_index(req_index),
    .req_level(req_level), .global_interrupt_enable(global_interrupt_enable));
`default_nettype wire

// >>> sim/iep_core_model.sv
// Purpose: Core model that acknowledges a presented request.
// Assumes: Acknowledge is a one-cycle pulse.
// Notes: Answers only while on is high.
`timescale 1ns/10ps
`default_nettype none
module iep_core_model (
    input  wire logic clk, // Clock.
    input  wire logic rst, // Reset.
    input  wire logic on,  // Acknowledge allowed.
    input  wire logic req, // Request presented.
    input  wire logic gie, // Master enable.
    output var  logic ack  // Acknowledge pulse.
);
    always @(posedge clk or posedge rst) begin
        if (rst)
            ack <= 1'b0;
        else
            ack <= on && req && gie && !ack;
    end
endmodule // iep_core_model
`default_nettype wire

// >>> sim/iep_tb_top.sv
// Purpose: Self-checking bench for iep_top.
// Assumes: Zero-wait APB; reads are scored from a queue.
// Notes: Random stimulus from a fixed seed.
`timescale 1ns/10ps
`default_nettype none
module interrupt_enable_priority_select_tb_top;
    logic        clk, rst, psel, penable, pwrite, ei, interrupt_return_instruction, di, on, lv, c0, c1;
    logic        pready, pslverr, ack, rv, gie, irq;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [6:0]  pend, h, l;
    logic [7:0]  pa, pr, es, ss, prev, cur;
    logic [4:1]  pd;
    logic [2:0]  ri;
    logic [1:0]  rl;
    logic [32:0] exp_q[$];
    integer      n_fail = 0, num_checks = 0, seed = 98, k, n, c;
    logic [11:0] ix[5] = '{12'hFC7, 12'hFC8, 12'hFCD, 12'hFCE, 12'hFCF};
    logic [7:0]  mk[5] = '{8'h7F, 8'h7F, 8'hFF, 8'hFE, 8'h80};
    iep_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ei_pulse(ei), .interrupt_return_instruction_pulse(interrupt_return_instruction), .di_pulse(di), .ack_pulse(ack), .g2_pending(pend),
        .port_a(pa), .port_d(pd), .low_voltage(lv), .comp0(c0), .comp1(c1), .pin_request(pr),
        .req_valid(rv), .req_index(ri), .req_level(rl), .global_interrupt_enable(gie), .irq(irq));
    iep_core_model u_core (.clk(clk), .rst(rst), .on(on), .req(rv), .gie(gie), .ack(ack));
    task stop_test;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [32:0] got, input logic [32:0] want);
        num_checks = num_checks + 1;
        if (got !== want) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task apb(input logic w, input logic [11:0] i, input logic [7:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'b00, i, 2'b00, 24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge clk); k = k + 1; end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin n_fail = n_fail + 1; stop_test; end
        {psel, penable} <= 2'b00;
    endtask
    task rd(input logic [11:0] i, input logic [8:0] e);
        exp_q.push_back({e[8], 24'h0, e[7:0]});
        apb(1'b0, i, 8'h00);
    endtask
    task pulse(input logic [2:0] p);
        @(posedge clk);
        {ei, interrupt_return_instruction, di} <= p;
        @(posedge clk);
        {ei, interrupt_return_instruction, di} <= 3'b000;
    endtask
    function logic [7:0] pick(input logic [6:0] p, input logic g);
        integer i;
        logic [1:0] b;
        logic [2:0] x;
        b = 2'b00;
        x = 3'h0;
        for (i = 0; i < 7; i++)
            if (p[i] && {h[i], l[i]} != 2'b00 && {h[i], l[i]} >= b) begin b = {h[i], l[i]}; x = i; end
        pick = (g && b != 2'b00) ? {2'b01, x, b} : 8'h00;
    endfunction
    function logic [7:0] lines(input logic [7:0] s);
        lines = {s[7] ? lv : pa[7], s[6] ? c0 : pa[6], s[5] ? c1 : pa[5],
                 (s[4:1] & pd) | (~s[4:1] & pa[4:1]), pa[0]};
    endfunction
    always @(posedge clk)
        if (psel && penable && !pwrite && pready)
            chk({pslverr, prdata}, exp_q.pop_front());
    initial begin clk = 1'b0; forever #50 clk = ~clk; end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ei, interrupt_return_instruction, di, on, pend, pa, pd, lv, c0, c1} = '0;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (c = 0; c < 5; c++) rd(ix[c], 9'h000);
        rd(12'hFD0, 9'h000);
        wr_irq: begin
            apb(1'b1, 12'hFD1, 8'h00);
            pulse(3'b001);
            #1 chk(irq, 0);
            apb(1'b1, 12'hFD1, 8'h02);
            #1 chk(irq, 1);
            rd(12'hFD0, 9'h002);
            #1 chk(irq, 0);
        end
        $display("test reset and irq done");
        for (c = 0; c < 7; c++) begin
            pulse(c[0] ? 3'b001 : ((c == 2 || c == 6) ? 3'b010 : 3'b100));
            #1 chk(gie, !c[0]);
        end
        apb(1'b1, 12'hFCF, 8'h80);
        #1 chk(gie, 1);
        apb(1'b1, 12'hFCF, 8'h00);
        #1 chk(gie, 0);
        $display("test master enable done");
        for (c = 0; c < 5; c++) begin
            r = $random(seed);
            apb(1'b1, ix[c], r[7:0] & mk[c]);
            rd(ix[c], {1'b0, r[7:0] & mk[c]});
        end
        rd(12'h000, 9'h100);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        for (c = 0; c < 5; c++) rd(ix[c], 9'h000);
        $display("test registers done");
        for (n = 0; n < 12; n++) begin
            r = $random(seed);
            {h, l} = {r[6:0], r[14:8]};
            apb(1'b1, 12'hFC7, {1'b0, h});
            pend <= r[22:16];
            apb(1'b1, 12'hFC8, {1'b0, l});
            pulse(n[0] ? 3'b100 : 3'b001);
            @(posedge clk);
            #1 chk({rv, rv ? {ri, rl} : 5'h00}, pick(r[22:16], n[0]));
        end
        apb(1'b1, 12'hFC7, 8'h7F);
        pend <= 7'h7F;
        on <= 1'b1;
        pulse(3'b010);
        for (k = 0; k < 10 && gie !== 1'b0; k++) @(posedge clk);
        #1 chk(gie, 0);
        @(posedge clk);
        on <= 1'b0;
        rd(12'hFD0, 9'h007);
        rd(12'hFD0, 9'h000);
        $display("test priority done");
        for (c = 0; c < 3; c++) begin
            r = $random(seed);
            {es, ss} = {r[7:0], r[15:8] & 8'hFE};
            apb(1'b1, 12'hFCD, es);
            apb(1'b1, 12'hFCE, ss);
            @(posedge clk);
            #1 prev = lines(ss);
            @(posedge clk);
            for (n = 0; n < 16; n++) begin
                r = $random(seed);
                {pa, pd, lv, c0, c1} <= r[14:0];
                @(posedge clk);
                #1 cur = lines(ss);
                chk(pr, (cur ^ prev) & ~(cur ^ es));
                prev = cur;
                @(posedge clk);
            end
        end
        $display("test edges done");
        stop_test;
    end
endmodule // interrupt_enable_priority_select_tb_top
`default_nettype wire
